// *** pmcs_defs.svh ***
`ifndef PMCS_DEFS_SVH
`define PMCS_DEFS_SVH
// index of each chip in the init/monitor sequence
`define PMCS_CHIP_DRIVER   2'h0
`define PMCS_CHIP_AMP      2'h1
`define PMCS_CHIP_CDR      2'h2
`define PMCS_CHIP_COUNT    2'h3
`define PMCS_CHIP_LAST     2'h2
// enhanced options byte: soft tx disable and soft power-down implemented
`define PMCS_ENH_OPTIONS   8'h60
`define PMCS_OPT_SOFT_TX   6
`define PMCS_OPT_SOFT_PD   5
// monitor poll spacing
`define PMCS_POLL_NS       1000
`define PMCS_CLK_NS        10
`define PMCS_POLL_CYCLES   ((`PMCS_POLL_NS) / (`PMCS_CLK_NS))
`define PMCS_POLL_W        8
`endif

// *** pmcs_pkg.sv ***
package pmcs_pkg;
	typedef enum logic [1:0] {
		PMCS_STANDBY = 2'b00,
		PMCS_INIT    = 2'b01,
		PMCS_MONITOR = 2'b11
	} pmcs_state_t;
endpackage

// *** pmcs_chip_if.sv ***
`timescale 1ns/100ps
interface pmcs_chip_if;
	logic       req;
	logic       wr;
	logic [1:0] chip;
	logic       ack;
	logic [7:0] rdata;
	modport ctrl (output req, output wr, output chip, input ack, input rdata);
	modport port (input req, input wr, input chip, output ack, output rdata);
endinterface

// *** pmcs_chip_port.sv ***
`timescale 1ns/100ps
`include "pmcs_defs.svh"
// registered handshake toward the driver, amplifier and recovery chips
module pmcs_chip_port (
	input  wire logic       core_clk,
	input  wire logic       rst,
	pmcs_chip_if.port       bus,
	output logic            chip_req,
	output logic            chip_wr,
	output logic [1:0]      chip_sel,
	input  wire logic       chip_ack,
	input  wire logic [7:0] chip_rdata
);
	always_ff @(posedge core_clk) begin
		if (rst) begin
			chip_req <= 1'b0;
			chip_wr  <= 1'b0;
			chip_sel <= 2'h0;
		end else begin
			chip_req <= bus.req & ~chip_ack;
			chip_wr  <= bus.wr;
			chip_sel <= bus.chip;
		end
	end
	assign bus.ack   = chip_ack & chip_req;
	assign bus.rdata = chip_rdata;
endmodule

// *** pmcs_top.sv ***
`timescale 1ns/100ps
`include "pmcs_defs.svh"
module pmcs_top (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       tx_off_request,
	input  wire logic       mgmt_deselect,
	input  wire logic       power_down_reset,
	input  wire logic       soft_tx_off,
	input  wire logic       soft_power_down,
	input  wire logic       mgmt_cmd_in,
	input  wire logic       rx_power_low,
	input  wire logic       tx_lock_lost,
	input  wire logic       rx_lock_lost,
	input  wire logic       laser_failed,
	input  wire logic       irq_clear,
	input  wire logic       chip_ack,
	input  wire logic [7:0] chip_rdata,
	output logic            laser_enable,
	output logic            rx_signal_lost,
	output logic            module_not_ready_out,
	output logic            module_missing_out,
	output logic            interrupt_out,
	output logic [2:0]      irq_cause,
	output logic            mgmt_cmd_out,
	output logic            mgmt_reset,
	output logic            standby,
	output logic [7:0]      enh_options,
	output logic [7:0]      chip_status [3],
	output logic            chip_req,
	output logic            chip_wr,
	output logic [1:0]      chip_sel
);
	// pin synchronisers
	logic [8:0] sync1;
	logic [8:0] sync2;
	always_ff @(posedge core_clk) begin
		sync1 <= {tx_off_request, mgmt_deselect, power_down_reset, soft_tx_off, soft_power_down,
			rx_power_low, tx_lock_lost, rx_lock_lost, laser_failed};
		sync2 <= sync1;
	end
	wire s_tx_off  = sync2[8];
	wire s_desel   = sync2[7];
	wire s_pdr     = sync2[6];
	wire s_soft_tx = sync2[5];
	wire s_soft_pd = sync2[4];
	wire s_rx_low  = sync2[3];
	wire s_tx_lol  = sync2[2];
	wire s_rx_lol  = sync2[1];
	wire s_las_f   = sync2[0];

	logic pdr_prev;
	logic cmd1;
	logic cmd2;
	always_ff @(posedge core_clk) begin
		pdr_prev <= s_pdr;
		cmd1     <= mgmt_cmd_in;
		cmd2     <= cmd1;
	end
	wire pdr_fall   = pdr_prev & ~s_pdr;
	wire full_reset = rst | pdr_fall;
	wire hold_down  = s_pdr | s_soft_pd;
	wire fault_now  = s_tx_lol | s_rx_lol | s_las_f;
	wire [2:0] cause_now = {s_rx_low, fault_now, s_tx_off};

	pmcs_chip_if cif ();
	pmcs_chip_port u_port (
		.core_clk   (core_clk),
		.rst        (full_reset),
		.bus        (cif),
		.chip_req   (chip_req),
		.chip_wr    (chip_wr),
		.chip_sel   (chip_sel),
		.chip_ack   (chip_ack),
		.chip_rdata (chip_rdata)
	);

	pmcs_pkg::pmcs_state_t state;
	pmcs_pkg::pmcs_state_t next_state;
	logic [1:0]                 chip_idx;
	logic [`PMCS_POLL_W-1:0]    poll_cnt;
	wire  step_done = cif.ack;
	wire  last_chip = (chip_idx == `PMCS_CHIP_LAST);
	wire  poll_due  = (poll_cnt == `PMCS_POLL_W'(`PMCS_POLL_CYCLES - 1));

	always_comb begin
		next_state = state;
		unique case (state)
			pmcs_pkg::PMCS_STANDBY: begin
				if (!hold_down) next_state = pmcs_pkg::PMCS_INIT;
			end
			pmcs_pkg::PMCS_INIT: begin
				if (hold_down) next_state = pmcs_pkg::PMCS_STANDBY;
				else if (step_done && last_chip) next_state = pmcs_pkg::PMCS_MONITOR;
			end
			pmcs_pkg::PMCS_MONITOR: begin
				if (hold_down) next_state = pmcs_pkg::PMCS_STANDBY;
			end
			default: next_state = pmcs_pkg::PMCS_STANDBY;
		endcase
	end

	wire in_init = (state == pmcs_pkg::PMCS_INIT);
	wire in_mon  = (state == pmcs_pkg::PMCS_MONITOR);
	assign cif.req  = (in_init | (in_mon & poll_due)) & ~hold_down;
	assign cif.wr   = in_init;
	assign cif.chip = chip_idx;

	logic [1:0]              next_chip_idx;
	logic [`PMCS_POLL_W-1:0] next_poll_cnt;
	wire  idx_restart = (next_state != state) | (step_done & last_chip);
	wire  poll_clear  = ~in_mon | step_done;
	assign next_chip_idx = idx_restart ? `PMCS_CHIP_DRIVER : (step_done ? chip_idx + 2'h1 : chip_idx);
	assign next_poll_cnt = poll_clear ? '0 : (poll_due ? poll_cnt : poll_cnt + `PMCS_POLL_W'(1));

	always_ff @(posedge core_clk) begin
		if (full_reset) begin
			state <= pmcs_pkg::PMCS_STANDBY;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge core_clk) begin
		if (full_reset) begin
			chip_idx <= `PMCS_CHIP_DRIVER;
		end else begin
			chip_idx <= next_chip_idx;
		end
	end

	always_ff @(posedge core_clk) begin
		if (full_reset) begin
			poll_cnt <= '0;
		end else begin
			poll_cnt <= next_poll_cnt;
		end
	end

	// per-chip status captured from polls
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_stat
			always_ff @(posedge core_clk) begin
				if (full_reset) chip_status[g] <= 8'h00;
				else if (step_done && in_mon && chip_idx == 2'(g)) chip_status[g] <= cif.rdata;
			end
		end
	endgenerate

	wire       next_laser_enable = in_mon & ~s_tx_off & ~s_soft_tx & ~hold_down;
	wire       next_rx_lost      = s_rx_low;
	wire       next_not_ready    = fault_now | ~in_mon;
	wire       next_cmd_out      = cmd2 & ~s_desel;
	wire       next_standby      = hold_down | ~in_mon;
	wire [2:0] next_irq_cause    = (irq_clear ? 3'h0 : irq_cause) | cause_now;
	wire       next_interrupt    = (|cause_now) | (~irq_clear & interrupt_out);

	always_ff @(posedge core_clk) begin
		if (full_reset) begin
			laser_enable <= 1'b0;
		end else begin
			laser_enable <= next_laser_enable;
		end
	end

	always_ff @(posedge core_clk) begin
		if (full_reset) begin
			rx_signal_lost <= 1'b0;
		end else begin
			rx_signal_lost <= next_rx_lost;
		end
	end

	always_ff @(posedge core_clk) begin
		if (full_reset) begin
			module_not_ready_out <= 1'b1;
		end else begin
			module_not_ready_out <= next_not_ready;
		end
	end

	always_ff @(posedge core_clk) begin
		if (full_reset) begin
			mgmt_cmd_out <= 1'b0;
		end else begin
			mgmt_cmd_out <= next_cmd_out;
		end
	end

	always_ff @(posedge core_clk) begin
		if (full_reset) begin
			standby <= 1'b1;
		end else begin
			standby <= next_standby;
		end
	end

	always_ff @(posedge core_clk) begin
		if (full_reset) begin
			irq_cause <= 3'h0;
		end else begin
			irq_cause <= next_irq_cause;
		end
	end

	always_ff @(posedge core_clk) begin
		if (full_reset) begin
			interrupt_out <= 1'b0;
		end else begin
			interrupt_out <= next_interrupt;
		end
	end

	always_ff @(posedge core_clk) begin
		mgmt_reset         <= full_reset;
		module_missing_out <= 1'b0;
		enh_options        <= `PMCS_ENH_OPTIONS;
	end
endmodule

// *** pmcs_chip_model.sv ***
`timescale 1ns/100ps
// far-side chip set: acks each access, promptly or after 3 cycles
module pmcs_chip_model (
	input  wire logic       core_clk,
	input  wire logic       chip_req,
	input  wire logic [1:0] chip_sel,
	input  wire logic       slow,
	output logic            chip_ack,
	output logic [7:0]      chip_rdata
);
	logic [1:0] wait_cnt = 2'h0;
	initial chip_ack = 1'b0;
	initial chip_rdata = 8'h00;
	always @(posedge core_clk) begin
		if (!chip_req) begin
			chip_ack <= 1'b0;
			wait_cnt <= 2'h0;
			chip_rdata <= ~chip_rdata;
		end else if (wait_cnt < (slow ? 2'h3 : 2'h0)) begin
			wait_cnt <= wait_cnt + 2'h1;
		end else begin
			chip_ack <= 1'b1;
			chip_rdata <= 8'h10 + {6'h00, chip_sel};
		end
	end
endmodule

// *** pmcs_top_chk.sv ***
`timescale 1ns/100ps
module pmcs_top_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic tx_off_request,
	input wire logic mgmt_deselect,
	input wire logic power_down_reset,
	input wire logic soft_tx_off,
	input wire logic rx_power_low,
	input wire logic tx_lock_lost,
	input wire logic rx_lock_lost,
	input wire logic laser_failed,
	input wire logic irq_clear,
	input wire logic chip_ack,
	input wire logic laser_enable,
	input wire logic rx_signal_lost,
	input wire logic module_not_ready_out,
	input wire logic module_missing_out,
	input wire logic interrupt_out,
	input wire logic mgmt_cmd_out,
	input wire logic mgmt_reset,
	input wire logic standby,
	input wire logic chip_req,
	input wire logic chip_wr,
	input wire logic [1:0] chip_sel
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_txoff; tx_off_request[*4] |-> !laser_enable; endproperty
	a_txoff: assert property (p_txoff) else $error("laser on while tx off");
	property p_los; rx_power_low[*4] |-> rx_signal_lost; endproperty
	a_los: assert property (p_los) else $error("signal lost not shown");
	property p_fault; (tx_lock_lost || rx_lock_lost || laser_failed)[*4] |-> module_not_ready_out; endproperty
	a_fault: assert property (p_fault) else $error("fault not shown");
	property p_desel; mgmt_deselect[*4] |-> !mgmt_cmd_out; endproperty
	a_desel: assert property (p_desel) else $error("command passed while deselected");
	property p_irq; interrupt_out && !irq_clear |=> interrupt_out || mgmt_reset; endproperty
	a_irq: assert property (p_irq) else $error("interrupt dropped without clear");
	property p_pd; power_down_reset[*4] |-> standby && !chip_req; endproperty
	a_pd: assert property (p_pd) else $error("not in standby");
	property p_pdrst; $fell(power_down_reset) |-> ##[2:5] mgmt_reset; endproperty
	a_pdrst: assert property (p_pdrst) else $error("no reset after falling edge");
	property p_abs; !module_missing_out; endproperty
	a_abs: assert property (p_abs) else $error("presence output high");
	property p_soft; soft_tx_off[*4] |-> !laser_enable; endproperty
	a_soft: assert property (p_soft) else $error("laser on while soft off");
	property p_wr; chip_wr |-> module_not_ready_out; endproperty
	a_wr: assert property (p_wr) else $error("chip written outside init");
	property p_order;
		(chip_req && chip_ack && chip_wr && chip_sel == 2'h0)
			|-> ##[2:12] (chip_req && chip_wr && chip_sel == 2'h1);
	endproperty
	a_order: assert property (p_order) else $error("init order broken");
	c_ack: cover property (chip_req && chip_ack);
	c_irq: cover property (interrupt_out ##1 !interrupt_out);
	c_pd: cover property ($fell(power_down_reset));
endmodule
bind pmcs_top pmcs_top_chk pmcs_top_chk_inst (.*);

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
	logic core_clk = 0, rst = 1, slow = 0;
	logic irq_clear, laser_failed, rx_lock_lost, tx_lock_lost, rx_power_low, mgmt_cmd_in;
	logic soft_power_down, soft_tx_off, power_down_reset, mgmt_deselect, tx_off_request;
	logic [10:0] p = 11'h000;
	logic laser_enable, rx_signal_lost, module_not_ready_out, module_missing_out, interrupt_out;
	logic mgmt_cmd_out, mgmt_reset, standby, chip_ack, chip_req, chip_wr;
	logic [2:0] irq_cause;
	logic [1:0] chip_sel;
	logic [7:0] enh_options, chip_rdata;
	logic [7:0] chip_status [3];
	int miscompares = 0, check_count = 0, cyc = 0, i;
	assign {irq_clear, laser_failed, rx_lock_lost, tx_lock_lost, rx_power_low, mgmt_cmd_in,
		soft_power_down, soft_tx_off, power_down_reset, mgmt_deselect, tx_off_request} = p;
	pmcs_top pmcs_top_inst (.*);
	pmcs_chip_model pmcs_chip_model_inst (.*);
	initial forever #5 core_clk = ~core_clk;
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task chk(string n, logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task set(int b, logic v, int n);
		@(posedge core_clk) p[b] <= v;
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	always @(posedge core_clk) if (++cyc > 4000) begin
		miscompares++;
		tally_and_finish;
	end
	task up(int n);
		set(0, 0, n);
		chk("laser_enable", 1, laser_enable);
		chk("chip_wr", 0, chip_wr);
	endtask
	task polled;
		for (i = 0; i < 3; i++) chk("chip_status", 8'h10 + 8'(i), chip_status[i]);
	endtask
	logic [3:0] host_s1, host_s2;
	always @(posedge core_clk) begin
		host_s1 <= {module_missing_out, module_not_ready_out, rx_signal_lost, interrupt_out};
		host_s2 <= host_s1;
	end
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 0;
		up(330);
		polled;
		chk("missing", 0, module_missing_out);
		chk("host_missing", 0, host_s2[3]);
		chk("enh_options", 8'h60, enh_options);
		set(0, 1, 5);
		chk("laser_enable", 0, laser_enable);
		up(5);
		set(3, 1, 5);
		chk("laser_enable", 0, laser_enable);
		set(3, 0, 0);
		set(10, 1, 0);
		set(10, 0, 2);
		chk("interrupt_out", 0, interrupt_out);
		chk("irq_cause", 0, irq_cause);
		set(6, 1, 5);
		chk("rx_signal_lost", 1, rx_signal_lost);
		chk("interrupt_out", 1, interrupt_out);
		set(6, 0, 5);
		chk("rx_signal_lost", 0, rx_signal_lost);
		chk("irq_cause", 8'h04, irq_cause);
		set(10, 1, 0);
		set(10, 0, 2);
		chk("interrupt_out", 0, interrupt_out);
		for (i = 7; i < 10; i++) begin
			set(i, 1, 5);
			chk("not_ready", 1, module_not_ready_out);
			chk("host_not_ready", 1, host_s2[2]);
			set(i, 0, 5);
			chk("not_ready", 0, module_not_ready_out);
		end
		set(1, 1, 0);
		set(5, 1, 5);
		chk("mgmt_cmd_out", 0, mgmt_cmd_out);
		set(1, 0, 5);
		chk("mgmt_cmd_out", 1, mgmt_cmd_out);
		set(4, 1, 5);
		chk("standby", 1, standby);
		chk("laser_enable", 0, laser_enable);
		set(4, 0, 0);
		up(30);
		slow <= 1;
		set(2, 1, 5);
		chk("standby", 1, standby);
		chk("laser_enable", 0, laser_enable);
		set(2, 0, 6);
		chk("standby", 1, standby);
		chk("interrupt_out", 0, interrupt_out);
		chk("chip_status", 0, chip_status[0]);
		up(345);
		polled;
		tally_and_finish;
	end
endmodule
